// *** nes_map.vh ***
// register offsets, fields, command codes and timing values in ns
`ifndef NES_MAP_VH
`define NES_MAP_VH
// word addresses on the register bus, one 32-bit register each
`define NES_OFS_STATUS 4'h0
`define NES_OFS_INDEX 4'h1
`define NES_OFS_PARAM 4'h2
`define NES_OFS_PROT 4'h3
`define NES_OFS_IRQ_STAT 4'h4
`define NES_OFS_IRQ_MASK 4'h5
`define NES_OFS_SEC 4'h6
// status register fields
`define NES_ST_CCF 7
`define NES_ST_ACC 5
`define NES_ST_PV 4
`define NES_ST_VE 1
`define NES_ST_VF 0
// protection register fields
`define NES_PR_FLASH 0
`define NES_PR_EE 1
`define NES_PR_SECT 2
// irq bits
`define NES_IRQ_DONE 0
`define NES_IRQ_ERR 1
// command codes
`define NES_CMD_BLK 8'h09
`define NES_CMD_SECT 8'h0A
`define NES_CMD_UNSEC 8'h0B
// parameter indexes
`define NES_IDX_0 3'h0
`define NES_IDX_1 3'h1
// valid block field values of address [23:16]
`define NES_BLK_FLASH 8'h00
`define NES_BLK_EE 8'h80
// timing
`define NES_ERASE_NS 2000
`define NES_CLK_NS 100
`endif

// *** nes_sync.v ***
// two flip-flop level synchroniser
`timescale 1ns/10ps
module nes_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // data
  input wire [W-1:0] in_async,
  output wire [W-1:0] out_sync
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
    end
    else
    begin
      s1_q <= in_async;
      s2_q <= s1_q;
    end
  end
  assign out_sync = s2_q;
endmodule

// *** nes_eng.v ***
// erase and verify engine working over the memory array interface
`timescale 1ns/10ps
`include "nes_map.vh"
module nes_eng #(
  parameter CW = 8
) (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // control
  input wire start,
  input wire [1:0] scope,
  input wire [CW-1:0] erase_cycles,
  // verify results from the array
  input wire vfy_err,
  input wire vfy_fatal,
  // array strobes
  output reg erase_on,
  output reg vfy_on,
  // result
  output reg done,
  output reg res_err,
  output reg res_fatal
);
  localparam S_IDLE = 2'd0;
  localparam S_ERASE = 2'd1;
  localparam S_VFY = 2'd2;
  reg [1:0] st_q;
  reg [CW-1:0] cnt_q;
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= S_IDLE;
      cnt_q <= {CW{1'b0}};
      erase_on <= 1'b0;
      vfy_on <= 1'b0;
      done <= 1'b0;
      res_err <= 1'b0;
      res_fatal <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (st_q)
        S_IDLE:
        begin
          if (start)
          begin
            st_q <= S_ERASE;
            cnt_q <= erase_cycles;
            erase_on <= 1'b1;
            res_err <= 1'b0;
            res_fatal <= 1'b0;
          end
        end
        S_ERASE:
        begin
          if (cnt_q <= {{(CW-1){1'b0}}, 1'b1})
          begin
            erase_on <= 1'b0;
            vfy_on <= 1'b1;
            st_q <= S_VFY;
          end
          else
          begin
            cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
          end
        end
        S_VFY:
        begin
          vfy_on <= 1'b0;
          res_err <= vfy_err | vfy_fatal;
          res_fatal <= vfy_fatal;
          done <= 1'b1;
          st_q <= S_IDLE;
        end
        default:
        begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// *** nes_seq.v ***
// erase and unsecure command sequencer with avalon-mm register slave
//
// Local design decisions: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`include "nes_map.vh"
module nes_seq #(
  parameter ERASE_NS = `NES_ERASE_NS
) (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // avalon-mm slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // mode availability pins, one per command: block, sector, unsecure
  input wire [2:0] mode_allow,
  // memory array verify result pins
  input wire vfy_err_pin,
  input wire vfy_fatal_pin,
  // memory array control
  output reg erase_active,
  output reg verify_active,
  output reg [1:0] erase_scope,
  output reg erase_ee,
  output reg [23:0] erase_addr,
  // security and interrupt
  output reg secure_out,
  output reg irq
);
  localparam ECYC = (ERASE_NS + `NES_CLK_NS - 1) / `NES_CLK_NS;
  // three cycles at least: verify pins reach the engine through two flops
  localparam [7:0] ECYC8 = (ECYC < 3) ? 8'h03 : ECYC[7:0];
  localparam SC_BLK = 2'd0;
  localparam SC_SECT = 2'd1;
  localparam SC_ALL = 2'd2;

  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  wire [4:0] pins_s;
  nes_sync #(.W(5)) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .in_async({mode_allow, vfy_err_pin, vfy_fatal_pin}),
    .out_sync(pins_s)
  );
  wire [2:0] allow_s = pins_s[4:2];
  wire verr_s = pins_s[1];
  wire vfat_s = pins_s[0];

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  reg command_complete_flag_q;
  reg access_error_flag_q;
  reg protection_violation_flag_q;
  reg verify_error_flag_q;
  reg verify_fatal_error_flag_q;
  reg [2:0] param_index_q;
  reg [15:0] command_param_word_q [0:1];
  reg [2:0] prot_q;
  reg [1:0] irq_stat_q;
  reg [1:0] irq_mask_q;
  reg secure_q;
  reg unsec_run_q;
  reg [1:0] scope_q;
  reg eng_start_q;

  wire [7:0] cmd = command_param_word_q[0][15:8];
  wire [7:0] blk = command_param_word_q[0][7:0];
  wire [15:0] alo = command_param_word_q[1];
  // a write acts at the edge that ends the transfer, waitrequest low
  wire wr_acc = avs_write & ~avs_waitrequest;
  // readdata is formed one edge earlier so that it stands at that edge
  wire rd_acc = avs_read & avs_waitrequest;
  wire launch = wr_acc && avs_address == `NES_OFS_STATUS &&
                avs_writedata[`NES_ST_CCF] && command_complete_flag_q;

  // -------------------------------------------------------------
  // launch checks
  // -------------------------------------------------------------
  reg chk_acc;
  reg chk_pv;
  reg known;
  always @*
  begin
    chk_acc = 1'b0;
    chk_pv = 1'b0;
    known = 1'b1;
    if (cmd == `NES_CMD_BLK)
    begin
      chk_acc = (param_index_q != `NES_IDX_1) | ~allow_s[0] |
                (blk != `NES_BLK_FLASH && blk != `NES_BLK_EE);
      chk_pv = blk[7] ? prot_q[`NES_PR_EE] : prot_q[`NES_PR_FLASH];
    end
    else if (cmd == `NES_CMD_SECT)
    begin
      chk_acc = (param_index_q != `NES_IDX_1) | ~allow_s[1] |
                (blk != `NES_BLK_FLASH && blk != `NES_BLK_EE) |
                (alo[1:0] != 2'b00);
      chk_pv = prot_q[`NES_PR_SECT];
    end
    else if (cmd == `NES_CMD_UNSEC)
    begin
      chk_acc = (param_index_q != `NES_IDX_0) | ~allow_s[2];
      chk_pv = |prot_q;
    end
    else
    begin
      // unknown code: refused with an access error
      known = 1'b0;
      chk_acc = 1'b1;
    end
  end

  // -------------------------------------------------------------
  // erase engine
  // -------------------------------------------------------------
  wire e_on;
  wire v_on;
  wire e_done;
  wire e_err;
  wire e_fat;
  nes_eng #(.CW(8)) u_eng (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(eng_start_q),
    .scope(scope_q),
    .erase_cycles(ECYC8),
    .vfy_err(verr_s),
    .vfy_fatal(vfat_s),
    .erase_on(e_on),
    .vfy_on(v_on),
    .done(e_done),
    .res_err(e_err),
    .res_fatal(e_fat)
  );

  // -------------------------------------------------------------
  // command and status control
  // -------------------------------------------------------------
  wire launch_bad = launch & (chk_acc | chk_pv);
  wire done_ev = e_done | launch_bad;
  wire err_ev = launch_bad | (e_done & e_err);
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      command_complete_flag_q <= 1'b1;
      access_error_flag_q <= 1'b0;
      protection_violation_flag_q <= 1'b0;
      verify_error_flag_q <= 1'b0;
      verify_fatal_error_flag_q <= 1'b0;
      param_index_q <= 3'h0;
      command_param_word_q[0] <= 16'h0000;
      command_param_word_q[1] <= 16'h0000;
      prot_q <= 3'h0;
      irq_mask_q <= 2'h0;
      secure_q <= 1'b1;
      unsec_run_q <= 1'b0;
      scope_q <= SC_BLK;
      eng_start_q <= 1'b0;
    end
    else
    begin
      eng_start_q <= 1'b0;
      if (wr_acc && avs_address == `NES_OFS_STATUS)
      begin
        if (avs_writedata[`NES_ST_ACC])
          access_error_flag_q <= 1'b0;
        if (avs_writedata[`NES_ST_PV])
          protection_violation_flag_q <= 1'b0;
      end
      if (launch)
      begin
        // verify flags restart at every launch
        verify_error_flag_q <= 1'b0;
        verify_fatal_error_flag_q <= 1'b0;
        if (chk_acc)
          access_error_flag_q <= 1'b1;
        if (chk_pv && known)
          protection_violation_flag_q <= 1'b1;
        if (!(chk_acc || chk_pv))
        begin
          command_complete_flag_q <= 1'b0;
          eng_start_q <= 1'b1;
          unsec_run_q <= (cmd == `NES_CMD_UNSEC);
          scope_q <= (cmd == `NES_CMD_BLK) ? SC_BLK :
                     (cmd == `NES_CMD_SECT) ? SC_SECT : SC_ALL;
        end
      end
      // writes other than status flag clears are dropped while busy, so an unsecure run is safe
      if (wr_acc && command_complete_flag_q)
      begin
        if (avs_address == `NES_OFS_INDEX)
          param_index_q <= avs_writedata[2:0];
        else if (avs_address == `NES_OFS_PARAM && param_index_q < 3'h2)
          command_param_word_q[param_index_q[0]] <= avs_writedata[15:0];
        else if (avs_address == `NES_OFS_PROT)
          prot_q <= avs_writedata[2:0];
        else if (avs_address == `NES_OFS_IRQ_MASK)
          irq_mask_q <= avs_writedata[1:0];
      end
      if (e_done)
      begin
        command_complete_flag_q <= 1'b1;
        verify_error_flag_q <= e_err;
        verify_fatal_error_flag_q <= e_fat;
        unsec_run_q <= 1'b0;
        // only a clean unsecure run releases security
        if (unsec_run_q && !e_err)
          secure_q <= 1'b0;
      end
    end
  end
  // error at launch: complete stays set, memory untouched

  // -------------------------------------------------------------
  // interrupt status, cleared by read, set wins
  // -------------------------------------------------------------
  // cleared where readdata is formed, so no event slips between
  wire rd_irq = rd_acc && avs_address == `NES_OFS_IRQ_STAT;
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      irq_stat_q <= 2'h0;
    else
      irq_stat_q <= (rd_irq ? 2'h0 : irq_stat_q) | {err_ev, done_ev};
  end

  // -------------------------------------------------------------
  // bus answer and outputs
  // -------------------------------------------------------------
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      irq <= 1'b0;
      secure_out <= 1'b1;
      erase_active <= 1'b0;
      verify_active <= 1'b0;
      erase_scope <= 2'h0;
      erase_ee <= 1'b0;
      erase_addr <= 24'h000000;
    end
    else
    begin
      // one wait state, then waitrequest low for a single cycle
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      avs_readdata <= 32'h00000000;
      if (rd_acc)
      begin
        if (avs_address == `NES_OFS_STATUS)
          avs_readdata <= {24'h000000, command_complete_flag_q, 1'b0,
                           access_error_flag_q,
                           protection_violation_flag_q, 2'b00,
                           verify_error_flag_q, verify_fatal_error_flag_q};
        else if (avs_address == `NES_OFS_INDEX)
          avs_readdata <= {29'h00000000, param_index_q};
        else if (avs_address == `NES_OFS_PARAM && param_index_q < 3'h2)
          avs_readdata <= {16'h0000, command_param_word_q[param_index_q[0]]};
        else if (avs_address == `NES_OFS_PROT)
          avs_readdata <= {29'h00000000, prot_q};
        else if (avs_address == `NES_OFS_IRQ_STAT)
          avs_readdata <= {30'h00000000, irq_stat_q};
        else if (avs_address == `NES_OFS_IRQ_MASK)
          avs_readdata <= {30'h00000000, irq_mask_q};
        else if (avs_address == `NES_OFS_SEC)
          avs_readdata <= {31'h00000000, secure_q};
      end
      irq <= |(irq_stat_q & irq_mask_q);
      secure_out <= secure_q;
      erase_active <= e_on;
      verify_active <= v_on;
      erase_scope <= scope_q;
      erase_ee <= blk[7];
      erase_addr <= {blk, alo};
    end
  end
endmodule

// *** nes_checker.sv ***
// assertion checker on the nes_seq ports
`timescale 1ns/10ps
module nes_checker #(
  parameter ERASE_NS = 2000
) (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // bus
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  // array control
  input wire erase_active,
  input wire verify_active,
  input wire [1:0] erase_scope,
  input wire erase_ee,
  input wire [23:0] erase_addr,
  input wire secure_out
);
  localparam int EC = ERASE_NS / 100;
  logic [7:0] ecnt_q;
  always @(posedge ref_clk or negedge rstn)
    if (!rstn)
      ecnt_q <= 8'h00;
    else
      ecnt_q <= erase_active ? ecnt_q + 8'h01 : 8'h00;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  bus_ans_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |-> ##[1:2] !avs_waitrequest) else $error("bus not answered");
  bus_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  bus_cause_a: assert property (!avs_waitrequest
    |-> $past(avs_read || avs_write)) else $error("answer without request");
  erase_len_a: assert property ($fell(erase_active)
    |-> ecnt_q >= EC - 1 && ecnt_q <= EC + 1) else $error("erase length");
  vfy_after_a: assert property ($fell(erase_active)
    |-> ##[0:1] verify_active) else $error("no verify after erase");
  vfy_pulse_a: assert property (verify_active |=> !verify_active)
    else $error("verify pulse too long");
  phase_excl_a: assert property (!(erase_active && verify_active))
    else $error("erase and verify overlap");
  blk_sel_a: assert property (erase_active
    && erase_scope != 2'h2 |-> erase_ee == erase_addr[23]
    && erase_addr[22:16] == 7'h00) else $error("block select");
  sect_align_a: assert property (erase_active && erase_scope == 2'h1
    |-> erase_addr[1:0] == 2'h0) else $error("sector misaligned");
  scope_hold_a: assert property (erase_active && $past(erase_active)
    |-> $stable(erase_scope) && $stable(erase_addr)) else $error("target moved");
  sec_keep_a: assert property (!$rose(secure_out))
    else $error("security raised");
  sec_rel_a: assert property ($fell(secure_out)
    |-> erase_scope == 2'h2) else $error("release without unsecure");
  cover property ($rose(erase_active) && erase_scope == 2'h1);
  cover property ($rose(erase_active) && erase_scope == 2'h2);
  cover property ($fell(secure_out));
endmodule
bind nes_seq nes_checker #(.ERASE_NS(ERASE_NS)) nes_checker_inst (
  .ref_clk(ref_clk),
  .rstn(rstn),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .erase_active(erase_active),
  .verify_active(verify_active),
  .erase_scope(erase_scope),
  .erase_ee(erase_ee),
  .erase_addr(erase_addr),
  .secure_out(secure_out)
);

// *** nes_arr.sv ***
// memory array model answering the verify phase
`timescale 1ns/10ps
module nes_arr (
  // clock
  input wire ref_clk,
  // array state from the sequencer
  input wire erase_active,
  input wire verify_active,
  // fault injection
  input wire bad_e,
  input wire bad_f,
  // verify results
  output logic vfy_err_pin,
  output logic vfy_fatal_pin
);
  logic tog_q = 1'b0;
  always @(posedge ref_clk)
    tog_q <= !tog_q;
  // results valid only while busy, noise otherwise
  always @*
    if (erase_active || verify_active)
    begin
      vfy_err_pin = bad_e;
      vfy_fatal_pin = bad_f;
    end
    else
    begin
      vfy_err_pin = tog_q;
      vfy_fatal_pin = !tog_q;
    end
endmodule

// *** testbench.sv ***
// self-checking bench for the erase and unsecure sequencer
`timescale 1ns/10ps
`include "nes_map.vh"
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [2:0] mode_allow = 3'h7;
  logic bad_e = 1'b0;
  logic bad_f = 1'b0;
  logic vfy_err_pin, vfy_fatal_pin, erase_active, verify_active;
  logic erase_ee, secure_out, irq;
  logic [1:0] erase_scope;
  logic [23:0] erase_addr;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [32:0] note_q [$];
  logic [31:0] rdat;
  logic [15:0] r16;
  // exp, code, hi, lo, index, mode, protection
  logic [43:0] ecase [13] = '{44'hA0090000070, 44'hA0090000160,
    44'hA00A0000150, 44'hA00B0000030, 44'hA0094000170, 44'hA00A0001170,
    44'h90090000171, 44'h90098000172, 44'h900A0000174, 44'h900B0000072,
    44'hA00B0000170, 44'hA00A4000170, 44'hA03F0000170};
  initial forever #50 ref_clk = !ref_clk;
  nes_seq #(.ERASE_NS(400)) nes_seq_inst (.ref_clk(ref_clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mode_allow(mode_allow),
    .vfy_err_pin(vfy_err_pin), .vfy_fatal_pin(vfy_fatal_pin),
    .erase_active(erase_active), .verify_active(verify_active),
    .erase_scope(erase_scope), .erase_ee(erase_ee),
    .erase_addr(erase_addr), .secure_out(secure_out), .irq(irq));
  nes_arr nes_arr_inst (.ref_clk(ref_clk), .erase_active(erase_active),
    .verify_active(verify_active), .bad_e(bad_e), .bad_f(bad_f),
    .vfy_err_pin(vfy_err_pin), .vfy_fatal_pin(vfy_fatal_pin));
  task automatic close_out;
    if (err_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do
    begin
      @(posedge ref_clk);
    end
    while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic c);
    note_q.push_back({c, e});
    bus(1'b0, a, 32'h0);
  endtask
  always @(posedge ref_clk)
    if (avs_read && avs_waitrequest === 1'b0 && note_q.size() > 0)
    begin
      if (note_q[0][32])
        `CHK("readdata", note_q[0][31:0], avs_readdata)
      void'(note_q.pop_front());
    end
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      close_out;
    end
  end
  task automatic cmd(input logic [7:0] c, h, input logic [15:0] l,
    input logic [2:0] x);
    wr(`NES_OFS_INDEX, 32'h0);
    wr(`NES_OFS_PARAM, {16'h0, c, h});
    wr(`NES_OFS_INDEX, 32'h1);
    wr(`NES_OFS_PARAM, {16'h0, l});
    wr(`NES_OFS_INDEX, {29'h0, x});
    wr(`NES_OFS_STATUS, 32'h80);
  endtask
  task automatic good(input logic [7:0] c, h, input logic [15:0] l,
    input logic [1:0] s, input logic [7:0] e);
    int n;
    cmd(c, h, l, s == 2'h2 ? 3'h0 : 3'h1);
    n = 0;
    while (erase_active !== 1'b1 && n < 10)
    begin
      @(posedge ref_clk);
      n++;
    end
    `CHK("erase start", 1'b1, erase_active)
    `CHK("scope", s, erase_scope)
    if (s != 2'h2)
    begin
      `CHK("addr", {h, l}, erase_addr)
      `CHK("ee", h[7], erase_ee)
    end
    n = 0;
    do
    begin
      rd(`NES_OFS_STATUS, 32'h0, 1'b0);
      n++;
    end
    while (rdat[7] !== 1'b1 && n < 50);
    rd(`NES_OFS_STATUS, {24'h0, e}, 1'b1);
  endtask
  initial
  begin
    r16 = $urandom(32'h1fba1172);
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(`NES_OFS_STATUS, 32'h80, 1'b1);
    rd(`NES_OFS_SEC, 32'h1, 1'b1);
    rd(4'hF, 32'h0, 1'b1);
    wr(`NES_OFS_SEC, 32'h0);
    rd(`NES_OFS_SEC, 32'h1, 1'b1);
    wr(`NES_OFS_PROT, 32'h0);
    good(8'h09, 8'h00, $urandom, 2'h0, 8'h80);
    good(8'h09, 8'h80, $urandom, 2'h0, 8'h80);
    r16 = $urandom;
    good(8'h0A, 8'h00, {r16[15:2], 2'h0}, 2'h1, 8'h80);
    bad_e <= 1'b1;
    good(8'h09, 8'h00, 16'h0, 2'h0, 8'h82);
    bad_f <= 1'b1;
    good(8'h0A, 8'h80, 16'h0, 2'h1, 8'h83);
    bad_f <= 1'b0;
    good(8'h0B, 8'h00, 16'h0, 2'h2, 8'h82);
    rd(`NES_OFS_SEC, 32'h1, 1'b1);
    `CHK("secure pin", 1'b1, secure_out)
    bad_e <= 1'b0;
    foreach (ecase[i])
    begin
      mode_allow <= ecase[i][6:4];
      wr(`NES_OFS_PROT, {29'h0, ecase[i][2:0]});
      cmd(ecase[i][35:28], ecase[i][27:20], {8'h0, ecase[i][19:12]},
        ecase[i][10:8]);
      rd(`NES_OFS_STATUS, {24'h0, ecase[i][43:36]}, 1'b1);
      `CHK("skip", 1'b0, erase_active)
      wr(`NES_OFS_STATUS, 32'h30);
    end
    mode_allow <= 3'h7;
    wr(`NES_OFS_PROT, 32'h0);
    `CHK("irq masked", 1'b0, irq)
    wr(`NES_OFS_IRQ_MASK, 32'h3);
    repeat (2) @(posedge ref_clk);
    `CHK("irq", 1'b1, irq)
    rd(`NES_OFS_IRQ_STAT, 32'h3, 1'b1);
    repeat (2) @(posedge ref_clk);
    `CHK("irq clear", 1'b0, irq)
    good(8'h0B, 8'h00, 16'h0, 2'h2, 8'h80);
    rd(`NES_OFS_SEC, 32'h0, 1'b1);
    `CHK("secure pin", 1'b0, secure_out)
    rd(`NES_OFS_IRQ_STAT, 32'h1, 1'b1);
    close_out;
  end
endmodule
